// ### design/dpw_wiper_slave.v
/*
 two-wire serial slave holding the 7-bit wiper position register of a
 128-tap potentiometer, with start/stop detect, address match, ack and
 delayed tap update.
 assumes the serial clock and data lines are asynchronous pins and the
 data line is open drain, its level resolved outside from the enable.
*/
// Function
// RQ1 - ignore all bus traffic until a start condition is seen
// RQ2 - start is data falling while clock high
// RQ3 - stop is data rising while clock high
// RQ4 - master ends every operation with a stop
// RQ5 - transmitter changes data only while the clock is low
// RQ6 - any data change while clock high is start or stop
// RQ7 - master begins a transfer only on an idle bus
// RQ8 - master makes the clock; device is slave only
// RQ9 - receiver pulls data low in ninth clock to acknowledge
// RQ10 - acknowledge the address byte only on a type id match
// RQ11 - unmatched device stays unselected for the rest of the transfer
// RQ12 - first byte: id in top seven bits, low bit one reads
// RQ13 - id sits in fixed bits; variants differ by id value
// RQ14 - selected for write, acknowledge every received byte
// RQ15 - read: send eight bits, release, sample ack, continue on ack
// RQ16 - on master no-ack stop sending and wait for stop
// RQ17 - ready for read and write within 1 ms of power
// RQ18 - tap follows a write between 5 and 10 us later
// RQ19 - power-up tap position set between 5 and 10 us; the code sets the tap to 40h one clock after reset release
// RQ20 - suppress input pulses of 50 ns or less
// RQ21 - 7-bit volatile wiper register, loaded with 40h at power-up
// RQ22 - ignore written top bit; read it back as zero
// RQ23 - write: address, register byte 00h, data, stop; update after third ack
// RQ24 - read: address write, 00h, repeated start, address read, data out
// RQ25 - decode register to exactly one of 128 tap selects
`timescale 1ns/10ps
`include "dpw_consts.vh"

module dpw_wiper_slave #(
    parameter [6:0] TYPE_ID = `DPW_DEF_TYPE_ID  // arbitrary neutral value
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_scl,
    input wire i_sda,
    output reg o_sda_out,
    output reg o_sda_oe,
    output reg [6:0] o_wiper_pos,
    output reg [127:0] o_tap_sel,
    output reg o_ready
);
    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    // one hot; an unknown code falls back to idle through the default
    // branch rather than leaving the data line pulled
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_RX = 6'h02;
    localparam [5:0] ST_ACK = 6'h04;
    localparam [5:0] ST_TX = 6'h08;
    localparam [5:0] ST_MACK = 6'h10;
    localparam [5:0] ST_WAIT = 6'h20;

    // ------------------------------------------------------------------
    // synchronisers and glitch filter
    // ------------------------------------------------------------------
    reg [1:0] scl_sync_ff;
    reg [1:0] sda_sync_ff;
    reg scl_hist_ff;
    reg sda_hist_ff;
    reg scl_ff;
    reg sda_ff;
    reg nxt_scl;
    reg nxt_sda;
    // two stages only; nothing else reads the first stage
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], i_scl};
            sda_sync_ff <= {sda_sync_ff[0], i_sda};
        end
    end

    // a level is taken once two samples agree, so a pulse of one clock
    // period or less never passes; two samples, not three, keep our answer
    // on the data line well ahead of the next clock rise at fast bus rates
    always @* begin
        nxt_scl = scl_ff;
        nxt_sda = sda_ff;
        if ({scl_hist_ff, scl_sync_ff[1]} == `DPW_SET_BITS) nxt_scl = 1'b1; // RQ20
        else if ({scl_hist_ff, scl_sync_ff[1]} == 2'h0) nxt_scl = 1'b0; // RQ20
        if ({sda_hist_ff, sda_sync_ff[1]} == `DPW_SET_BITS) nxt_sda = 1'b1; // RQ20
        else if ({sda_hist_ff, sda_sync_ff[1]} == 2'h0) nxt_sda = 1'b0; // RQ20
    end

    // filtered levels; reset to the idle high of both lines
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_hist_ff <= 1'b1;
            sda_hist_ff <= 1'b1;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_hist_ff <= scl_sync_ff[1];
            sda_hist_ff <= sda_sync_ff[1];
            scl_ff <= nxt_scl;
            sda_ff <= nxt_sda;
        end
    end

    // bus events from the filtered level against its registered copy;
    // a data change under a high clock is never a data bit
    wire scl_rise = nxt_scl & ~scl_ff;
    wire scl_fall = ~nxt_scl & scl_ff;
    wire start_det = nxt_scl & scl_ff & sda_ff & ~nxt_sda; // RQ2 RQ6
    wire stop_det = nxt_scl & scl_ff & ~sda_ff & nxt_sda; // RQ3 RQ6

    // ------------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------------
    // the byte index saturates at 3, so a long write cannot wrap back
    // onto the register byte and rewrite the pointer flag
    reg [5:0] state_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] shift_ff;
    reg [1:0] byte_idx_ff;  // 0 address, 1 register byte, 2 data
    reg is_read_ff;
    reg ack_ok_ff;          // whether the byte just received is acked
    reg reg_ok_ff;          // register byte was 00h
    reg [6:0] wiper_ff;
    reg upd_req_ff;
    reg [7:0] nxt_shift;

    // received bits enter at the bottom, most significant first
    always @* begin
        nxt_shift = {shift_ff[6:0], sda_ff};
    end

    // one engine for receive, acknowledge and transmit; every drive change
    // is made on a clock fall so the data line never moves under a high
    // clock, and a stop wins over anything in flight
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            byte_idx_ff <= 2'h0;
            is_read_ff <= 1'b0;
            ack_ok_ff <= 1'b0;
            reg_ok_ff <= 1'b0;
            wiper_ff <= `DPW_WIPER_RESET; // RQ21
            upd_req_ff <= 1'b0;
            o_sda_out <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            upd_req_ff <= 1'b0;
            o_sda_out <= 1'b0;
            if (stop_det) begin
                state_ff <= ST_IDLE; // RQ4
                o_sda_oe <= 1'b0;
            end else if (start_det && o_ready) begin
                // repeated start too; register pointer stays valid
                state_ff <= ST_RX; // RQ1 RQ24
                bit_cnt_ff <= 4'h0;
                byte_idx_ff <= 2'h0;
                o_sda_oe <= 1'b0;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        o_sda_oe <= 1'b0; // RQ1
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_ff <= nxt_shift;
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                            state_ff <= ST_ACK;
                            if (byte_idx_ff == 2'h0) begin
                                // RQ10 RQ12 RQ13
                                ack_ok_ff <= (shift_ff[`DPW_ID_TOP:`DPW_ID_BOTTOM] == TYPE_ID);
                                is_read_ff <= shift_ff[`DPW_RW_BIT];
                                o_sda_oe <= (shift_ff[`DPW_ID_TOP:`DPW_ID_BOTTOM] == TYPE_ID);
                            end else begin
                                ack_ok_ff <= 1'b1; // RQ14
                                o_sda_oe <= 1'b1; // RQ9
                                if (byte_idx_ff == 2'h1) begin
                                    reg_ok_ff <= (shift_ff == `DPW_REG_ADDR);
                                end else if (byte_idx_ff == 2'h2 && reg_ok_ff) begin
                                    // only the third byte writes; later ones are acked, dropped
                                    wiper_ff <= shift_ff[6:0]; // RQ22 RQ23
                                    upd_req_ff <= 1'b1; // RQ18
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= 4'h0;
                            if (!ack_ok_ff) begin
                                state_ff <= ST_WAIT; // RQ11
                                o_sda_oe <= 1'b0;
                            end else if (byte_idx_ff == 2'h0 && is_read_ff) begin
                                // loaded here so bit 7 is on the line before the first rise
                                state_ff <= ST_TX; // RQ15
                                shift_ff <= {1'b0, wiper_ff}; // RQ22
                                o_sda_oe <= 1'b1; // top bit is zero
                            end else begin
                                state_ff <= ST_RX;
                                o_sda_oe <= 1'b0;
                                if (byte_idx_ff != 2'h3) byte_idx_ff <= byte_idx_ff + 2'h1;
                            end
                        end
                    end
                    ST_TX: begin
                        // drive low for zero bits, change only on clock low
                        if (scl_fall) begin
                            if (bit_cnt_ff == 4'h7) begin
                                state_ff <= ST_MACK;
                                o_sda_oe <= 1'b0; // RQ15
                            end else begin
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                                shift_ff <= {shift_ff[6:0], 1'b0};
                                o_sda_oe <= ~shift_ff[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        // the master's answer is taken at the rise, acted on at the fall
                        if (scl_rise) begin
                            ack_ok_ff <= ~sda_ff;
                        end else if (scl_fall) begin
                            bit_cnt_ff <= 4'h0;
                            if (ack_ok_ff) begin
                                state_ff <= ST_TX; // RQ15
                                shift_ff <= {1'b0, wiper_ff};
                                o_sda_oe <= 1'b1;
                            end else begin
                                state_ff <= ST_WAIT; // RQ16
                                o_sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_WAIT: begin
                        // deaf to data until the next start or stop
                        o_sda_oe <= 1'b0; // RQ16
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // wiper settle timing and power-up
    // ------------------------------------------------------------------
    // one counter serves both the power-up load and each write; after a write
    // the tap moves a fixed 5.5 us later, inside the 5..10 us window
    reg [8:0] settle_cnt_ff;
    reg settle_run_ff;
    reg [6:0] nxt_pos;
    integer k;
    // end count held at the counter's own width
    localparam integer SETTLE_END_I = `DPW_SETTLE_CYC;
    localparam [8:0] SETTLE_END = SETTLE_END_I[8:0];
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            settle_cnt_ff <= 9'h000;
            settle_run_ff <= 1'b1; // RQ19
            o_wiper_pos <= `DPW_WIPER_RESET;
            o_ready <= 1'b0;
        end else begin
            if (upd_req_ff) begin
                settle_cnt_ff <= 9'h000; // RQ18
                settle_run_ff <= 1'b1;
            end else if (settle_run_ff) begin
                if (settle_cnt_ff == SETTLE_END) begin
                    settle_run_ff <= 1'b0;
                    o_wiper_pos <= wiper_ff; // RQ18 RQ19
                    o_ready <= 1'b1; // RQ17
                end else begin
                    settle_cnt_ff <= settle_cnt_ff + 9'h001;
                end
            end
        end
    end

    // one-hot tap decode from the settled position
    always @* begin
        nxt_pos = o_wiper_pos;
    end

    // all taps open while in reset; a one-cycle gap at release is the price
    // of a registered output, the switches never see two taps at once
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tap_sel <= 128'h0;
        end else begin
            for (k = 0; k < 128; k = k + 1) begin
                o_tap_sel[k] <= (nxt_pos == k[6:0]); // RQ25
            end
        end
    end
endmodule

// ### shared/dpw_consts.vh
/*
 constants for the two-wire wiper register slave: timing counts at the
 20 MHz system clock, register reset value and byte layout.
 assumes the includer works with a 50 ns clock period.
*/
`ifndef DPW_CONSTS_VH
`define DPW_CONSTS_VH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define DPW_CLK_NS 50
// ----------------------------------------------------------------------
// timing, figures in their own unit and derived counts
// ----------------------------------------------------------------------
`define DPW_GLITCH_NS 50
`define DPW_GLITCH_CYC ((`DPW_GLITCH_NS + `DPW_CLK_NS - 1) / `DPW_CLK_NS + 1)
`define DPW_SETTLE_MIN_US 5
`define DPW_SETTLE_MAX_US 10
`define DPW_SETTLE_MIN_CYC ((`DPW_SETTLE_MIN_US * 1000 + `DPW_CLK_NS - 1) / `DPW_CLK_NS)
`define DPW_SETTLE_MAX_CYC ((`DPW_SETTLE_MAX_US * 1000) / `DPW_CLK_NS)
`define DPW_SETTLE_CYC (`DPW_SETTLE_MIN_CYC + 10)
`define DPW_PWRUP_MS 1
`define DPW_PWRUP_MAX_CYC ((`DPW_PWRUP_MS * 1000000) / `DPW_CLK_NS)
// ----------------------------------------------------------------------
// register and byte layout
// ----------------------------------------------------------------------
`define DPW_WIPER_RESET 7'h40
`define DPW_REG_ADDR 8'h00
`define DPW_ID_TOP 7
`define DPW_ID_BOTTOM 1
`define DPW_RW_BIT 0
`define DPW_DEF_TYPE_ID 7'h2a
`define DPW_SET_BITS 2'h3
`endif

// ### tb/dpw_bus_master.sv
/*
 bus master model: makes the bus clock and drives the data line.
 assumes a pull-up on the data wire, whose level returns on i_sda.
*/
`timescale 1ns/10ps
module dpw_bus_master (
    input wire i_clk,
    input wire i_sda,
    output reg o_scl,
    output reg o_sda
);
    // ----
    // bus tasks, paced on falling system edges
    // ----
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task tick(input integer n);
        repeat (n) @(negedge i_clk);
    endtask
    // long clock-high phase so a start is never taken for a data slot
    task start;
        tick(1);
        o_sda = 1'b1;
        tick(8);
        o_scl = 1'b1;
        tick(6);
        o_sda = 1'b0;
        tick(6);
        o_scl = 1'b0;
    endtask
    task stop;
        tick(1);
        o_sda = 1'b0;
        tick(4);
        o_scl = 1'b1;
        tick(6);
        o_sda = 1'b1;
        tick(8);
    endtask
    // data moves one edge after the clock fall, never while it is high
    task bitx(input b, output r);
        tick(1);
        o_sda = b;
        tick(4);
        o_scl = 1'b1;
        tick(3);
        r = i_sda;
        o_scl = 1'b0;
    endtask
    // byte then ninth slot; ack is high when that slot was pulled low
    task xfer(input [7:0] d, input m, output [7:0] q, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) bitx(d[i], q[i]);
            bitx(m, r);
            ack = ~r;
        end
    endtask
endmodule

// ### tb/dpw_wiper_checker.sv
/*
 checker for the wiper slave, bound to its ports.
 assumes the bus is paced as in the bench master: five samples low, three high.
*/
`timescale 1ns/10ps
module dpw_wiper_checker (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_scl,
    input wire i_sda,
    input wire o_sda_out,
    input wire o_sda_oe,
    input wire [6:0] o_wiper_pos,
    input wire [127:0] o_tap_sel,
    input wire o_ready
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // cycles spent waiting for power-up settle
    logic [7:0] rdy_cnt_ff;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) rdy_cnt_ff <= 8'h00;
        else if (!o_ready && rdy_cnt_ff != 8'hff) rdy_cnt_ff <= rdy_cnt_ff + 8'h01;
    end
    // ----
    // assertions
    // ----
    sda_low_only_a: assert property (o_sda_out == 1'b0)
        else $error("data pin value not low");
    quiet_unready_a: assert property (!o_ready |-> !o_sda_oe && o_wiper_pos == 7'h40)
        else $error("activity before ready");
    ready_late_a: assert property (!o_ready |-> rdy_cnt_ff <= 8'hc8)
        else $error("power-up settle too slow");
    ready_early_a: assert property ($rose(o_ready) |-> rdy_cnt_ff >= 8'h64)
        else $error("power-up settle too fast");
    tap_decode_a: assert property ($stable(o_wiper_pos) [*3] ##0 o_ready
        |-> o_tap_sel == (128'h1 << o_wiper_pos))
        else $error("tap select not decoded");
    tap_onehot_a: assert property (o_ready |-> $onehot(o_tap_sel))
        else $error("tap select not one-hot");
    oe_after_fall_a: assert property ($changed(o_sda_oe)
        |-> $past(i_scl, 5) && !$past(i_scl, 4) && !i_scl)
        else $error("data drive moved off clock fall");
    stop_release_a: assert property (i_scl [*5] ##0 $rose(i_sda) |-> !o_sda_oe [*8])
        else $error("data driven after stop");
    cover property ($rose(o_ready));
    cover property ($rose(o_sda_oe));
    cover property ($changed(o_wiper_pos) && o_ready);
endmodule
bind dpw_wiper_slave dpw_wiper_checker dpw_wiper_checker_i (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_wiper_pos(o_wiper_pos), .o_tap_sel(o_tap_sel),
    .o_ready(o_ready));

// ### tb/tb_dpw_wiper_slave.sv
/*
 testbench: power-up, writes, read, foreign address, judged at the pins.
 assumes the master model paces the bus at 400 ns per bit.
*/
`timescale 1ns/10ps
`include "dpw_consts.vh"
module tb_dpw_wiper_slave;
    localparam [6:0] ID = `DPW_DEF_TYPE_ID;
    logic clk, arst_n, sda_out, oe, ready, ak;
    wire scl, m_sda, sda;
    logic [6:0] wiper;
    logic [127:0] tap;
    logic [7:0] q;
    time t0;
    integer err_total = 0;
    integer num_checks = 0;
    // open-drain wire with pull-up
    assign sda = m_sda & (oe ? sda_out : 1'b1);
    dpw_wiper_slave #(.TYPE_ID(ID)) dpw_wiper_slave_i (.i_clk(clk), .i_arst_n(arst_n),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
        .o_wiper_pos(wiper), .o_tap_sel(tap), .o_ready(ready));
    dpw_bus_master dpw_bus_master_i (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ----
    // helpers
    // ----
    task chk(input ok, input [8*12-1:0] what);
        num_checks = num_checks + 1;
        if (!ok) begin
            err_total = err_total + 1;
            $display("mismatch %0t %0s", $time, what);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait on a wiper value; gives up after 20 us
    task wait_pos(input [6:0] v);
        while (wiper !== v && $time - t0 < 20000) @(negedge clk);
        if (wiper !== v) begin
            chk(1'b0, "timeout");
            print_verdict;
        end
    endtask
    task addr_reg;
        dpw_bus_master_i.start;
        dpw_bus_master_i.xfer({ID, 1'b0}, 1'b1, q, ak);
        chk(ak === 1'b1, "addr ack");
        dpw_bus_master_i.xfer(`DPW_REG_ADDR, 1'b1, q, ak);
        chk(ak === 1'b1, "reg ack");
    endtask
    // ----
    // scenarios
    // ----
    task t_powerup;
        chk(wiper === `DPW_WIPER_RESET && tap === 128'h0, "reset");
        arst_n = 1'b1;
        t0 = $time;
        dpw_bus_master_i.start;
        dpw_bus_master_i.xfer({ID, 1'b0}, 1'b1, q, ak);
        chk(ak === 1'b0, "early ack");
        dpw_bus_master_i.stop;
        wait_pos(`DPW_WIPER_RESET);
        while (ready !== 1'b1 && $time - t0 < 15000) @(negedge clk);
        if (ready !== 1'b1) begin
            chk(1'b0, "ready late");
            print_verdict;
        end
        chk(($time - t0) / 50 >= 100 && ($time - t0) / 50 <= 201, "pwr settle");
        chk(tap === 128'h1 << 64, "pwr tap");
    endtask
    // top data bit must be dropped; tap moves 5..10 us after the ack
    task t_write(input [7:0] d);
        addr_reg;
        dpw_bus_master_i.xfer(d, 1'b1, q, ak);
        chk(ak === 1'b1, "data ack");
        t0 = $time;
        dpw_bus_master_i.stop;
        wait_pos(d[6:0]);
        chk(($time - t0) / 50 >= 100 && ($time - t0) / 50 <= 200, "settle");
        @(negedge clk);
        chk(tap === 128'h1 << d[6:0], "tap");
    endtask
    task t_read(input [6:0] v);
        addr_reg;
        dpw_bus_master_i.start;
        dpw_bus_master_i.xfer({ID, 1'b1}, 1'b1, q, ak);
        chk(ak === 1'b1, "read ack");
        dpw_bus_master_i.xfer(8'hff, 1'b0, q, ak);
        chk(q === {1'b0, v}, "read data");
        dpw_bus_master_i.xfer(8'hff, 1'b1, q, ak);
        chk(q === {1'b0, v}, "reread");
        dpw_bus_master_i.xfer(8'hff, 1'b1, q, ak);
        chk(q === 8'hff, "after nack");
        dpw_bus_master_i.stop;
    endtask
    task t_foreign;
        dpw_bus_master_i.start;
        dpw_bus_master_i.xfer({ID ^ 7'h01, 1'b0}, 1'b1, q, ak);
        chk(ak === 1'b0, "foreign ack");
        dpw_bus_master_i.xfer(`DPW_REG_ADDR, 1'b1, q, ak);
        dpw_bus_master_i.xfer(8'h05, 1'b1, q, ak);
        chk(ak === 1'b0, "foreign data");
        dpw_bus_master_i.stop;
        repeat (250) @(negedge clk);
        chk(wiper === 7'h13, "kept");
    endtask
    initial begin
        arst_n = 1'b0;
        repeat (4) @(negedge clk);
        t_powerup;
        t_write(8'hff);
        t_write(8'h00);
        t_write(8'h93);
        t_read(7'h13);
        t_foreign;
        print_verdict;
    end
endmodule
